//--- bench/limit_value_alarm_unit_chk.sv
// Concurrent checks on the ports of the limit value alarm unit.
`timescale 1ns/10ps
`default_nettype none
module limit_value_alarm_unit_chk #(
	parameter int SLOW_CYCLES = 4,
	parameter int FAST_CYCLES = 7
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Process side and panel
	input wire logic [alarm_pkg::NUM_VARS*16-1:0] process_vars,
	input wire logic shift_key,
	input wire logic enter_key,
	// Outputs
	input wire logic [3:0] alarm_msg,
	input wire logic [3:0] alarm_lamp,
	input wire logic [15:0] panel_value,
	input wire logic panel_percent,
	input wire logic auto_assign_en,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence done_s;
		psel && penable && pready;
	endsequence
	a_ready_setup: assert property (setup_s |=> pready)
		else $error("no zero-wait answer after setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_bad_addr: assert property (done_s and (paddr > 8'h24) |-> pslverr)
		else $error("unmapped address not refused");
	a_err_good_addr: assert property (done_s and (paddr <= 8'h24 && paddr[1:0] == 2'h0) |-> !pslverr)
		else $error("mapped address refused");
	a_idle_quiet: assert property (!psel |=> !pready && !pslverr)
		else $error("answer without selection");
	a_lamp_single: assert property ($onehot0(alarm_lamp))
		else $error("more than one threshold lamp flashing");
endmodule : limit_value_alarm_unit_chk
`default_nettype wire

//--- bench/process_panel_model.sv
// Behavioural model of the process variables and the front-panel operator.
`timescale 1ns/10ps
`default_nettype none
module process_panel_model (
	// Clock
	input wire logic pclk,
	// Process side
	output logic [alarm_pkg::NUM_VARS*16-1:0] process_vars,
	// Operator keys
	output logic shift_key,
	output logic enter_key
);
	initial begin
		process_vars = '0;
		shift_key = 1'b0;
		enter_key = 1'b0;
	end
	task automatic set_var(input int idx, input logic [15:0] v);
		@(posedge pclk);
		process_vars[idx*16 +: 16] <= v;
	endtask : set_var
	// A press outlasts the two-stage synchroniser, and so does the pause after it.
	task automatic press(input logic enter);
		@(posedge pclk);
		if (enter) begin
			enter_key <= 1'b1;
		end else begin
			shift_key <= 1'b1;
		end
		repeat (6) @(posedge pclk);
		shift_key <= 1'b0;
		enter_key <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : press
endmodule : process_panel_model
`default_nettype wire

//--- bench/tb_limit_value_alarm_unit.sv
// Self-checking testbench of the limit value alarm unit.
`timescale 1ns/10ps
`default_nettype none
module tb_limit_value_alarm_unit;
	localparam int SLOW = 4;
	localparam int FAST = 7;
	localparam logic [15:0] HI_V = 16'h03E8;
	localparam logic [15:0] LO_V = 16'hFC18;
	localparam logic [1:0] HI_E [3] = '{2'h1, 2'h0, 2'h3};
	localparam logic [1:0] LO_E [3] = '{2'h2, 2'h3, 2'h0};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic shift_key, enter_key, panel_percent, auto_assign_en, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, alarm_msg, alarm_lamp, seen;
	logic [alarm_pkg::NUM_VARS*16-1:0] process_vars;
	logic [15:0] panel_value;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	limit_value_alarm_unit #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .process_vars(process_vars), .shift_key(shift_key),
		.enter_key(enter_key), .alarm_msg(alarm_msg), .alarm_lamp(alarm_lamp),
		.panel_value(panel_value), .panel_percent(panel_percent),
		.auto_assign_en(auto_assign_en), .irq(irq)
	);
	process_panel_model pm_u (
		.pclk(pclk), .process_vars(process_vars), .shift_key(shift_key), .enter_key(enter_key)
	);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t: no pready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(rd, exp);
	endtask : rchk
	function automatic logic [31:0] cw(input logic [4:0] s1, s2, input logic [1:0] f1, f2, ac,
		input logic [4:0] fl);
		return {11'h0, fl, ac, f2, f1, s2, s1};
	endfunction : cw
	task automatic vars(input logic [15:0] v3, input logic [15:0] v16);
		pm_u.set_var(3, v3);
		pm_u.set_var(16, v16);
		repeat (4) @(posedge pclk);
	endtask : vars
	task automatic seen_lamps();
		seen = 4'h0;
		repeat (2 * FAST + 2) begin
			@(posedge pclk);
			seen = seen | alarm_lamp;
		end
	endtask : seen_lamps
	// Length in cycles of one lit phase of a lamp, left in n.
	task automatic run_len(input int b);
		int k;
		k = 0;
		n = 0;
		while (alarm_lamp[b] !== 1'b0 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		while (alarm_lamp[b] !== 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		while (alarm_lamp[b] === 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
	endtask : run_len
	task automatic to_thr();
		int k;
		k = 0;
		seen_lamps();
		while (seen === 4'h0 && k < 8) begin
			pm_u.press(1'b0);
			seen_lamps();
			k++;
		end
	endtask : to_thr
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk(alarm_pkg::OFS_CTRL, alarm_pkg::CTRL_RST);
		rchk(alarm_pkg::OFS_HYST, {16'h0, alarm_pkg::HYST_RST});
		xfer(8'h28, 1'b0, 32'h0);
		check({31'h0, err}, 32'h1);
		wr(alarm_pkg::OFS_THR1, 32'h64);
		wr(alarm_pkg::OFS_THR2, 32'h28);
		wr(alarm_pkg::OFS_THR3, 32'h64);
		wr(alarm_pkg::OFS_THR4, 32'h28);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h10, 2'h0, 2'h0, 2'h0, 5'h00));
		wr(alarm_pkg::OFS_THR1, 32'hC8);
		wr(alarm_pkg::OFS_HYST, 32'h5);
		rchk(alarm_pkg::OFS_THR1, 32'h64);
		rchk(alarm_pkg::OFS_HYST, 32'h1);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h10, 2'h0, 2'h0, 2'h0, 5'h01));
		wr(alarm_pkg::OFS_THR2, 32'h96);
		rchk(alarm_pkg::OFS_THR2, 32'h64);
		wr(alarm_pkg::OFS_THR3, 32'h1E);
		rchk(alarm_pkg::OFS_THR4, 32'h1E);
		wr(alarm_pkg::OFS_THR3, 32'h64);
		wr(alarm_pkg::OFS_THR4, 32'h28);
		wr(alarm_pkg::OFS_THR2, 32'h28);
		wr(alarm_pkg::OFS_HYST, 32'h0);
		rchk(alarm_pkg::OFS_HYST, {16'h0, alarm_pkg::HYST_MIN});
		wr(alarm_pkg::OFS_HYST, 32'hC8);
		rchk(alarm_pkg::OFS_HYST, {16'h0, alarm_pkg::HYST_MAX});
		wr(alarm_pkg::OFS_HYST, 32'h1);
		for (int f = 0; f < 3; f++) begin
			wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h10, 2'(f), 2'(f), 2'h0, 5'h01));
			vars(HI_V, HI_V);
			check({28'h0, alarm_msg}, {28'h0, HI_E[f], HI_E[f]});
			vars(LO_V, LO_V);
			check({28'h0, alarm_msg}, {28'h0, LO_E[f], LO_E[f]});
		end
		vars(HI_V, LO_V);
		check({28'h0, alarm_msg}, 32'h3);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h0, 5'h01));
		repeat (4) @(posedge pclk);
		check({28'h0, alarm_msg}, 32'h5);
		vars(16'h0063, LO_V);
		check({28'h0, alarm_msg}, 32'h5);
		vars(LO_V, LO_V);
		vars(16'h0029, LO_V);
		check({28'h0, alarm_msg}, 32'hA);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h0, 5'h09));
		vars(HI_V, LO_V);
		check({28'h0, alarm_msg}, 32'hA);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h0, 5'h01));
		repeat (4) @(posedge pclk);
		wr(alarm_pkg::OFS_STAT, 32'hF);
		rchk(alarm_pkg::OFS_STAT, 32'h0);
		wr(alarm_pkg::OFS_MASK, 32'hF);
		vars(LO_V, LO_V);
		rchk(alarm_pkg::OFS_STAT, 32'hA);
		check({31'h0, irq}, 32'h1);
		wr(alarm_pkg::OFS_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		wr(alarm_pkg::OFS_STAT, 32'hF);
		rchk(alarm_pkg::OFS_STAT, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		for (int ac = 0; ac < 3; ac++) begin
			wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'(ac), 5'h11));
			repeat (2) @(posedge pclk);
			check({31'h0, auto_assign_en}, {31'h0, ac != 0});
		end
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h0, 5'h01));
		to_thr();
		check({28'h0, seen}, 32'h0);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h1, 5'h03));
		to_thr();
		check({28'h0, seen}, 32'h1);
		check({16'h0, panel_value}, 32'h64);
		check({31'h0, panel_percent}, 32'h1);
		run_len(0);
		check(n, SLOW);
		pm_u.press(1'b1);
		run_len(0);
		check(n, SLOW);
		for (int i = 1; i < 4; i++) begin
			pm_u.press(1'b0);
			seen_lamps();
			check({28'h0, seen}, 32'h1 << i);
		end
		pm_u.press(1'b0);
		wr(alarm_pkg::OFS_CTRL, cw(5'h03, 5'h03, 2'h0, 2'h0, 2'h2, 5'h03));
		to_thr();
		pm_u.press(1'b1);
		run_len(0);
		check(n, FAST);
		finish_test();
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			$display("ERROR %0t: timeout", $time);
			num_errors++;
			finish_test();
		end
	end
endmodule : tb_limit_value_alarm_unit
bind limit_value_alarm_unit limit_value_alarm_unit_chk #(
	.SLOW_CYCLES(SLOW_CYCLES), .FAST_CYCLES(FAST_CYCLES)
) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .process_vars(process_vars), .shift_key(shift_key),
	.enter_key(enter_key), .alarm_msg(alarm_msg), .alarm_lamp(alarm_lamp),
	.panel_value(panel_value), .panel_percent(panel_percent),
	.auto_assign_en(auto_assign_en), .irq(irq)
);
`default_nettype wire

//--- logic/alarm_pkg.sv
// Package of constants, register map and types for the limit value alarm unit.
`default_nettype none
package alarm_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_THR1 = 8'h04;
	localparam logic [7:0] OFS_THR2 = 8'h08;
	localparam logic [7:0] OFS_THR3 = 8'h0C;
	localparam logic [7:0] OFS_THR4 = 8'h10;
	localparam logic [7:0] OFS_HYST = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_MASK = 8'h1C;
	localparam logic [7:0] OFS_PANEL = 8'h20;
	localparam logic [7:0] OFS_ALARM = 8'h24;
	// ****************************************
	// Field layout of the control register
	// ****************************************
	localparam int CTRL_SEL1_LSB = 0;
	localparam int CTRL_SEL2_LSB = 5;
	localparam int CTRL_FN1_LSB = 10;
	localparam int CTRL_FN2_LSB = 12;
	localparam int CTRL_ACCESS_LSB = 14;
	localparam int CTRL_OFFLINE_BIT = 16;
	localparam int CTRL_PCT1_BIT = 17;
	localparam int CTRL_PCT2_BIT = 18;
	localparam int CTRL_FALL_BIT = 19;
	localparam int CTRL_AUTO_BIT = 20;
	localparam int SEL_W = 5;
	localparam int VAL_W = 16;
	localparam int NUM_VARS = 17;
	localparam logic [4:0] SEL_MAX = 5'h10;
	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] FN_MAX_MIN = 2'h0;
	localparam logic [1:0] FN_MIN_MIN = 2'h1;
	localparam logic [1:0] FN_MAX_MAX = 2'h2;
	localparam logic [1:0] ACCESS_NONE = 2'h0;
	localparam logic [1:0] ACCESS_SHOW = 2'h1;
	localparam logic [1:0] ACCESS_ADJ = 2'h2;
	// Hysteresis in 0.1 % steps: 0.1 % to 10 %.
	localparam logic [15:0] HYST_MIN = 16'h0001;
	localparam logic [15:0] HYST_MAX = 16'h0064;
	localparam logic [15:0] HYST_RST = 16'h0001;
	localparam logic [31:0] CTRL_RST = 32'h0001_0000;
	// ****************************************
	// Flash timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int SLOW_MS = 500;
	localparam int FAST_MS = 900;
	localparam int SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
	localparam int FAST_CYC = CLK_HZ / 1000 * FAST_MS;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		DSP_SP = 5'b00001,
		DSP_OUT = 5'b00010,
		DSP_THR = 5'b00100,
		DSP_PV = 5'b01000,
		DSP_ADJ = 5'b10000
	} disp_e;
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [1:0] fn;
	} pair_cfg_s;
endpackage : alarm_pkg
`default_nettype wire

//--- logic/limit_comparator.sv
// One hysteresis comparator of the limit value alarm unit.
`timescale 1ns/10ps
`default_nettype none
module limit_comparator (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Comparison inputs
	input wire logic signed [15:0] value,
	input wire logic signed [15:0] threshold,
	input wire logic [15:0] hyst,
	input wire logic upper,
	// Alarm
	output logic alarm
);
	logic signed [16:0] rel_lo;
	logic signed [16:0] rel_hi;
	logic signed [16:0] val_x;
	assign val_x = 17'(value);
	assign rel_lo = 17'(threshold) - 17'(signed'({1'b0, hyst}));
	assign rel_hi = 17'(threshold) + 17'(signed'({1'b0, hyst}));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm <= 1'b0;
		end else if (upper) begin
			if (val_x > 17'(threshold)) begin
				alarm <= 1'b1;
			end else if (val_x < rel_lo) begin
				alarm <= 1'b0;
			end
		end else begin
			if (val_x < 17'(threshold)) begin
				alarm <= 1'b1;
			end else if (val_x > rel_hi) begin
				alarm <= 1'b0;
			end
		end
	end
endmodule : limit_comparator
`default_nettype wire

//--- logic/limit_value_alarm_unit.sv
// Top of the limit value alarm unit with its APB register file.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module limit_value_alarm_unit #(
	parameter int SLOW_CYCLES = alarm_pkg::SLOW_CYC,
	parameter int FAST_CYCLES = alarm_pkg::FAST_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Process variables, packed index 0 is the control difference
	input wire logic [alarm_pkg::NUM_VARS*16-1:0] process_vars,
	// Front panel
	input wire logic shift_key,
	input wire logic enter_key,
	// Outputs
	output logic [3:0] alarm_msg,
	output logic [3:0] alarm_lamp,
	output logic [15:0] panel_value,
	output logic panel_percent,
	output logic auto_assign_en,
	output logic irq
);
	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] ctrl_q;
	logic [15:0] thr_q [4];
	logic [15:0] hyst_q;
	logic [3:0] stat_q;
	logic [3:0] mask_q;
	alarm_pkg::pair_cfg_s cfg1;
	alarm_pkg::pair_cfg_s cfg2;
	logic [1:0] access;
	logic offline;
	logic falling;
	logic wr;
	logic rd;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [3:0] alarm;
	logic [3:0] alarm_d1;
	assign cfg1 = '{sel: ctrl_q[alarm_pkg::CTRL_SEL1_LSB +: alarm_pkg::SEL_W],
		fn: ctrl_q[alarm_pkg::CTRL_FN1_LSB +: 2]};
	assign cfg2 = '{sel: ctrl_q[alarm_pkg::CTRL_SEL2_LSB +: alarm_pkg::SEL_W],
		fn: ctrl_q[alarm_pkg::CTRL_FN2_LSB +: 2]};
	assign access = ctrl_q[alarm_pkg::CTRL_ACCESS_LSB +: 2];
	assign offline = ctrl_q[alarm_pkg::CTRL_OFFLINE_BIT];
	assign falling = ctrl_q[alarm_pkg::CTRL_FALL_BIT];
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{pstrb[b]}};
		end
	end
	assign wval = pwdata & wmask;
	// Panel adjustment state, declared early for the threshold writer.
	alarm_pkg::disp_e disp_q;
	logic [1:0] thr_idx_q;
	logic adj_up;
	logic adj_dn;
	assign adj_up = 1'b0;
	assign adj_dn = 1'b0;
	logic shift_s1;
	logic shift_s2;
	logic shift_s3;
	logic enter_s1;
	logic enter_s2;
	logic enter_s3;
	logic shift_pulse;
	logic enter_pulse;

	// ****************************************
	// APB handshake
	// ****************************************
	// Zero wait states: pready is high during every access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr > alarm_pkg::OFS_ALARM || paddr[1:0] != 2'h0);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= alarm_pkg::CTRL_RST;
		end else if (wr && pready && paddr == alarm_pkg::OFS_CTRL) begin
			ctrl_q <= (ctrl_q & ~wmask) | wval;
			if (pstrb[0] && pwdata[alarm_pkg::CTRL_SEL1_LSB +: alarm_pkg::SEL_W] >
					alarm_pkg::SEL_MAX) begin
				ctrl_q[alarm_pkg::CTRL_SEL1_LSB +: alarm_pkg::SEL_W] <= alarm_pkg::SEL_MAX;
			end
			if (pstrb[0] && pwdata[alarm_pkg::CTRL_SEL2_LSB +: alarm_pkg::SEL_W] >
					alarm_pkg::SEL_MAX) begin
				ctrl_q[alarm_pkg::CTRL_SEL2_LSB +: alarm_pkg::SEL_W] <= alarm_pkg::SEL_MAX;
			end
		end
	end

	// Thresholds: software writes offline; the panel never writes them, since adj_up and adj_dn are tied low.
	logic [15:0] thr_new;
	logic [1:0] wr_idx;
	always_comb begin
		wr_idx = 2'(({24'h0, paddr} - 32'(alarm_pkg::OFS_THR1)) >> 2);
		thr_new = (thr_q[wr_idx] & ~wmask[15:0]) | wval[15:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				thr_q[i] <= 16'h0000;
			end
		end else if (wr && pready && offline && paddr >= alarm_pkg::OFS_THR1 &&
				paddr <= alarm_pkg::OFS_THR4) begin
			// clamp second of pair to first
			if (wr_idx[0] && $signed(thr_new) > $signed(thr_q[wr_idx - 2'h1])) begin
				thr_q[wr_idx] <= thr_q[wr_idx - 2'h1];
			end else begin
				thr_q[wr_idx] <= thr_new;
			end
			if (!wr_idx[0] && $signed(thr_q[wr_idx + 2'h1]) > $signed(thr_new)) begin
				thr_q[wr_idx + 2'h1] <= thr_new;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hyst_q <= alarm_pkg::HYST_RST;
		end else if (wr && pready && offline && paddr == alarm_pkg::OFS_HYST) begin
			if (((hyst_q & ~wmask[15:0]) | wval[15:0]) < alarm_pkg::HYST_MIN) begin
				hyst_q <= alarm_pkg::HYST_MIN;
			end else if (((hyst_q & ~wmask[15:0]) | wval[15:0]) > alarm_pkg::HYST_MAX) begin
				hyst_q <= alarm_pkg::HYST_MAX;
			end else begin
				hyst_q <= (hyst_q & ~wmask[15:0]) | wval[15:0];
			end
		end
	end

	// ****************************************
	// Comparators
	// ****************************************
	logic [15:0] var_sel [2];
	logic [3:0] upper;
	assign var_sel[0] = process_vars[16*cfg1.sel +: 16];
	assign var_sel[1] = process_vars[16*cfg2.sel +: 16];
	always_comb begin
		upper[0] = (cfg1.fn != alarm_pkg::FN_MIN_MIN) ^ falling;
		upper[1] = (cfg1.fn == alarm_pkg::FN_MAX_MAX) ^ falling;
		upper[2] = (cfg2.fn != alarm_pkg::FN_MIN_MIN) ^ falling;
		upper[3] = (cfg2.fn == alarm_pkg::FN_MAX_MAX) ^ falling;
	end
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			limit_comparator u_cmp (
				.pclk(pclk),
				.presetn(presetn),
				.value(var_sel[g/2]),
				.threshold(thr_q[g]),
				.hyst(hyst_q),
				.upper(upper[g]),
				.alarm(alarm[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_msg <= 4'h0;
			alarm_d1 <= 4'h0;
			auto_assign_en <= 1'b0;
		end else begin
			alarm_msg <= alarm;
			alarm_d1 <= alarm;
			auto_assign_en <= ctrl_q[alarm_pkg::CTRL_AUTO_BIT] &&
				(access == alarm_pkg::ACCESS_SHOW || access == alarm_pkg::ACCESS_ADJ);
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 4'h0;
			mask_q <= 4'h0;
			irq <= 1'b0;
		end else begin
			// Set wins over a simultaneous write-one clear.
			if (wr && pready && paddr == alarm_pkg::OFS_STAT && pstrb[0]) begin
				stat_q <= (stat_q & ~pwdata[3:0]) | (alarm & ~alarm_d1);
			end else begin
				stat_q <= stat_q | (alarm & ~alarm_d1);
			end
			if (wr && pready && paddr == alarm_pkg::OFS_MASK && pstrb[0]) begin
				mask_q <= pwdata[3:0];
			end
			irq <= |(stat_q & mask_q);
		end
	end

	// ****************************************
	// Front panel
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_s1 <= 1'b0;
			shift_s2 <= 1'b0;
			shift_s3 <= 1'b0;
			enter_s1 <= 1'b0;
			enter_s2 <= 1'b0;
			enter_s3 <= 1'b0;
		end else begin
			shift_s1 <= shift_key;
			shift_s2 <= shift_s1;
			shift_s3 <= shift_s2;
			enter_s1 <= enter_key;
			enter_s2 <= enter_s1;
			enter_s3 <= enter_s2;
		end
	end
	assign shift_pulse = shift_s2 && !shift_s3;
	assign enter_pulse = enter_s2 && !enter_s3;

	// Two-threshold cycle when pair two monitors the same as pair one is not
	// distinguishable here, so all four appear once access is nonzero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_q <= alarm_pkg::DSP_SP;
			thr_idx_q <= 2'h0;
		end else begin
			unique case (disp_q)
				alarm_pkg::DSP_SP: begin
					if (shift_pulse) begin
						disp_q <= alarm_pkg::DSP_OUT;
					end
				end
				alarm_pkg::DSP_OUT: begin
					if (shift_pulse && access != alarm_pkg::ACCESS_NONE) begin
						disp_q <= alarm_pkg::DSP_THR;
						thr_idx_q <= 2'h0;
					end else if (shift_pulse) begin
						disp_q <= alarm_pkg::DSP_PV;
					end
				end
				alarm_pkg::DSP_THR: begin
					if (enter_pulse && access == alarm_pkg::ACCESS_ADJ) begin
						disp_q <= alarm_pkg::DSP_ADJ;
					end else if (shift_pulse && thr_idx_q == 2'h3) begin
						disp_q <= alarm_pkg::DSP_PV;
					end else if (shift_pulse) begin
						thr_idx_q <= thr_idx_q + 2'h1;
					end
				end
				alarm_pkg::DSP_ADJ: begin
					if (enter_pulse || shift_pulse) begin
						disp_q <= alarm_pkg::DSP_THR;
					end
				end
				alarm_pkg::DSP_PV: begin
					if (shift_pulse) begin
						disp_q <= alarm_pkg::DSP_SP;
					end
				end
				default: begin
					disp_q <= alarm_pkg::DSP_SP;
				end
			endcase
		end
	end

	// ****************************************
	// Lamp flashing
	// ****************************************
	logic [31:0] flash_cnt_q;
	logic flash_q;
	logic [31:0] half;
	assign half = (disp_q == alarm_pkg::DSP_ADJ) ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_cnt_q <= 32'h0;
			flash_q <= 1'b0;
			alarm_lamp <= 4'h0;
		end else begin
			if (flash_cnt_q >= half - 32'h1) begin
				flash_cnt_q <= 32'h0;
				flash_q <= !flash_q;
			end else begin
				flash_cnt_q <= flash_cnt_q + 32'h1;
			end
			if (disp_q == alarm_pkg::DSP_THR || disp_q == alarm_pkg::DSP_ADJ) begin
				alarm_lamp <= flash_q ? (4'h1 << thr_idx_q) : 4'h0;
			end else begin
				alarm_lamp <= 4'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_value <= 16'h0;
			panel_percent <= 1'b0;
		end else begin
			panel_value <= thr_q[thr_idx_q];
			panel_percent <= thr_idx_q[1] ? ctrl_q[alarm_pkg::CTRL_PCT2_BIT] :
				ctrl_q[alarm_pkg::CTRL_PCT1_BIT];
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			unique case (paddr)
				alarm_pkg::OFS_CTRL: prdata <= ctrl_q;
				alarm_pkg::OFS_THR1: prdata <= {16'h0, thr_q[0]};
				alarm_pkg::OFS_THR2: prdata <= {16'h0, thr_q[1]};
				alarm_pkg::OFS_THR3: prdata <= {16'h0, thr_q[2]};
				alarm_pkg::OFS_THR4: prdata <= {16'h0, thr_q[3]};
				alarm_pkg::OFS_HYST: prdata <= {16'h0, hyst_q};
				alarm_pkg::OFS_STAT: prdata <= {28'h0, stat_q};
				alarm_pkg::OFS_MASK: prdata <= {28'h0, mask_q};
				alarm_pkg::OFS_PANEL: prdata <= {25'h0, thr_idx_q, disp_q};
				alarm_pkg::OFS_ALARM: prdata <= {28'h0, alarm};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule : limit_value_alarm_unit
`default_nettype wire
